// *** rtl/dss_cfg.svh ***
// offsets, field positions, reset values and limits of the screen sequencer
`ifndef DSS_CFG_SVH
`define DSS_CFG_SVH
`define DSS_NUM_SCREENS 6
`define DSS_SCR_LAST 3'h5
`define DSS_SCR_FIRST 3'h0
`define DSS_OFF_CTRL 8'h00
`define DSS_OFF_DWELL 8'h04
`define DSS_OFF_MASK 8'h08
`define DSS_OFF_OPBR 8'h0C
`define DSS_OFF_SSBR 8'h10
`define DSS_OFF_SSTO 8'h14
`define DSS_OFF_STAT 8'h18
`define DSS_CTRL_MODE 0
`define DSS_CTRL_PREC 1
`define DSS_CTRL_SSM_LO 2
`define DSS_CTRL_SSM_HI 3
`define DSS_CTRL_EDIT 4
`define DSS_RST_MASK 6'h3F
`define DSS_RST_DWELL 12'h00A
`define DSS_DWELL_MIN 12'h001
`define DSS_DWELL_MAX 12'hE10
`define DSS_RST_OPBR 8'h7F
`define DSS_RST_SSBR 7'h20
`define DSS_SSBR_MAX 7'h7E
`define DSS_RST_SSTO 16'h0384
`define DSS_KEY_UP 0
`define DSS_KEY_DOWN 1
`define DSS_KEY_RIGHT 2
`define DSS_KEY_ENTER 3
`define DSS_KEY_ESC 4
`define DSS_KEY_TICK 5
`define DSS_NUM_INPUTS 6
`endif

// *** rtl/dss_key_sync.sv ***
// two-stage synchronisers and rising-edge pulses for pin inputs
`timescale 1ns/1ps
module dss_key_sync #(
	parameter int WIDTH = 6
)(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] rise_out
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			logic meta_reg;
			logic sync_reg;
			logic prev_reg;
			always_ff @(posedge clk_in or posedge rst_in)
			begin
				if (rst_in)
				begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
					prev_reg <= 1'b0;
				end
				else
				begin
					meta_reg <= pin_in[g];
					sync_reg <= meta_reg;
					prev_reg <= sync_reg;
				end
			end
			assign rise_out[g] = sync_reg & ~prev_reg;
		end
	endgenerate
endmodule

// *** rtl/dss_pkg.sv ***
// types of the screen sequencer
package dss_pkg;
	typedef enum logic [1:0] {DSS_SS_DISABLED = 2'h0, DSS_SS_LOW = 2'h1, DSS_SS_SCROLL = 2'h2, DSS_SS_OFF = 2'h3} dss_ss_mode_t;
	typedef enum logic [1:0] {DSS_SS_IDLE = 2'b01, DSS_SS_ACTIVE = 2'b10} dss_ss_state_t;
endpackage

// *** rtl/dss_sec_timer.sv ***
// seconds counter, saturating at its limit
`timescale 1ns/1ps
module dss_sec_timer #(
	parameter int WIDTH = 16
)(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic clear_in,
	input wire logic tick_in,
	input wire logic [WIDTH-1:0] limit_in,
	output logic reached_out
);
	logic [WIDTH-1:0] count_reg;
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			count_reg <= '0;
		else if (clear_in)
			count_reg <= '0;
		else if (tick_in && (count_reg < limit_in))
			count_reg <= count_reg + 1'b1;
	end
	assign reached_out = (count_reg >= limit_in);
endmodule

// *** rtl/dss_top.sv ***
// display screen sequencer with apb registers, mask editor and screensaver
//
// Overview of operation
// - static mode: up key shows next enabled screen, down key previous.
// - stepping past the last screen wraps to the first screen.
// - screens with cleared enable bit are skipped, by keys and automatically.
// - first screen is always enabled whatever the mask holds.
// - display mode static or dynamic; static after reset.
// - dynamic mode shows each screen for dwell seconds, 1 to 3600.
// - one enable bit per screen, six screens, in the mask register.
// - all screen enable bits set after reset.
// - mask edit: up/down pick line, right toggles, enter commits to storage.
// - operational brightness, 256 levels, default 127, while screensaver off.
// - screensaver modes disabled, low brightness, scrolling, off; scrolling default.
// - screensaver starts after timeout seconds without keys; default 900.
// - escape or joystick key restores brightness and clears inactivity timer.
// - low brightness mode uses separate screensaver brightness, 127 levels.
// - screensaver setting changes apply only at the next activation.
// - scrolling screensaver drives operational brightness.
// - precision normal by default; elevated adds one decimal digit.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "dss_cfg.svh"
module dss_top import dss_pkg::*; #(
	parameter int NUM_SCREENS = `DSS_NUM_SCREENS,
	parameter int DWELL_W = 12,
	parameter int SSTO_W = 16
)(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic KEY_UP_IN,
	input wire logic DOWN_KEY_IN,
	input wire logic KEY_RIGHT_IN,
	input wire logic ENTER_KEY_IN,
	input wire logic KEY_ESC_IN,
	input wire logic SEC_TICK_IN,
	input wire logic NV_LOAD_IN,
	input wire logic NV_MODE_IN,
	input wire logic [DWELL_W-1:0] NV_DWELL_IN,
	input wire logic [NUM_SCREENS-1:0] NV_MASK_IN,
	input wire logic [7:0] NV_OPBR_IN,
	output logic NV_SAVE_OUT,
	output logic [NUM_SCREENS-1:0] NV_MASK_OUT,
	output logic [2:0] PROCESS_VIEW_OUT,
	output logic [7:0] BRIGHT_OUT,
	output logic DISPLAY_ON_OUT,
	output logic SCROLL_OUT,
	output logic EXTRA_DIGIT_OUT,
	output logic SS_ACTIVE_OUT
);
	// ========================================
	// input synchronisers
	logic [`DSS_NUM_INPUTS-1:0] pins;
	logic [`DSS_NUM_INPUTS-1:0] rise;
	logic up_key, down_key, right_key, enter_key, esc_key, sec_tick, activity;
	assign pins = {SEC_TICK_IN, KEY_ESC_IN, ENTER_KEY_IN, KEY_RIGHT_IN, DOWN_KEY_IN, KEY_UP_IN};
	dss_key_sync #(
		.WIDTH(`DSS_NUM_INPUTS)
	) u_sync (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.pin_in(pins),
		.rise_out(rise)
	);
	assign up_key = rise[`DSS_KEY_UP];
	assign down_key = rise[`DSS_KEY_DOWN];
	assign right_key = rise[`DSS_KEY_RIGHT];
	assign enter_key = rise[`DSS_KEY_ENTER];
	assign esc_key = rise[`DSS_KEY_ESC];
	assign sec_tick = rise[`DSS_KEY_TICK];
	assign activity = up_key | down_key | right_key | enter_key | esc_key;

	// ========================================
	// registers
	logic mode_reg, prec_reg, edit_reg, nv_save_reg, disp_on_reg, scroll_reg;
	dss_ss_mode_t ssm_reg, ss_lat_mode_reg;
	dss_ss_state_t ss_state_reg;
	logic [DWELL_W-1:0] dwell_reg, dwell_next;
	logic [NUM_SCREENS-1:0] mask_reg, eff_mask;
	logic [7:0] opbr_reg, bright_reg;
	logic [6:0] ssbr_reg, ss_lat_br_reg, ssbr_next;
	logic [SSTO_W-1:0] ssto_reg;
	logic [2:0] screen_reg, cursor_reg;
	logic [31:0] prdata_reg;
	logic wr_en, rd_en, addr_hit;

	assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
	assign rd_en = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
	assign eff_mask = mask_reg | {{(NUM_SCREENS-1){1'b0}}, 1'b1};

	assign addr_hit = (PADDR_IN == `DSS_OFF_CTRL) | (PADDR_IN == `DSS_OFF_DWELL) | (PADDR_IN == `DSS_OFF_MASK) |
		(PADDR_IN == `DSS_OFF_OPBR) | (PADDR_IN == `DSS_OFF_SSBR) | (PADDR_IN == `DSS_OFF_SSTO) |
		(PADDR_IN == `DSS_OFF_STAT);

	// dwell clamped to its legal span
	assign dwell_next = (PWDATA_IN[DWELL_W-1:0] < `DSS_DWELL_MIN) ? `DSS_DWELL_MIN :
		(PWDATA_IN[DWELL_W-1:0] > `DSS_DWELL_MAX) ? `DSS_DWELL_MAX : PWDATA_IN[DWELL_W-1:0];
	assign ssbr_next = (PWDATA_IN[6:0] > `DSS_SSBR_MAX) ? `DSS_SSBR_MAX : PWDATA_IN[6:0];

	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_hit;
	assign PRDATA_OUT = prdata_reg;

	// ========================================
	// control register
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			mode_reg <= 1'b0;
			prec_reg <= 1'b0;
			ssm_reg <= DSS_SS_SCROLL;
			edit_reg <= 1'b0;
		end
		else if (wr_en && PADDR_IN == `DSS_OFF_CTRL)
		begin
			mode_reg <= PWDATA_IN[`DSS_CTRL_MODE];
			prec_reg <= PWDATA_IN[`DSS_CTRL_PREC];
			ssm_reg <= dss_ss_mode_t'(PWDATA_IN[`DSS_CTRL_SSM_HI:`DSS_CTRL_SSM_LO]);
			edit_reg <= PWDATA_IN[`DSS_CTRL_EDIT];
		end
		else if (NV_LOAD_IN)
			mode_reg <= NV_MODE_IN;
	end

	// ========================================
	// setting registers
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			dwell_reg <= `DSS_RST_DWELL;
			opbr_reg <= `DSS_RST_OPBR;
			ssbr_reg <= `DSS_RST_SSBR;
			ssto_reg <= `DSS_RST_SSTO;
		end
		else if (wr_en)
		begin
			if (PADDR_IN == `DSS_OFF_DWELL)
				dwell_reg <= dwell_next;
			if (PADDR_IN == `DSS_OFF_OPBR)
				opbr_reg <= PWDATA_IN[7:0];
			if (PADDR_IN == `DSS_OFF_SSBR)
				ssbr_reg <= ssbr_next;
			if (PADDR_IN == `DSS_OFF_SSTO)
				ssto_reg <= PWDATA_IN[SSTO_W-1:0];
		end
		else if (NV_LOAD_IN)
		begin
			dwell_reg <= (NV_DWELL_IN < `DSS_DWELL_MIN) ? `DSS_DWELL_MIN :
				(NV_DWELL_IN > `DSS_DWELL_MAX) ? `DSS_DWELL_MAX : NV_DWELL_IN;
			opbr_reg <= NV_OPBR_IN;
		end
	end

	// ========================================
	// screen mask and its editor
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			mask_reg <= `DSS_RST_MASK;
		else if (wr_en && PADDR_IN == `DSS_OFF_MASK)
			mask_reg <= PWDATA_IN[NUM_SCREENS-1:0];
		else if (NV_LOAD_IN)
			mask_reg <= NV_MASK_IN;
		else if (edit_reg && right_key)
			mask_reg[cursor_reg] <= ~mask_reg[cursor_reg];
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			cursor_reg <= `DSS_SCR_FIRST;
		else if (!edit_reg)
			cursor_reg <= `DSS_SCR_FIRST;
		else if (up_key)
			cursor_reg <= (cursor_reg == `DSS_SCR_LAST) ? `DSS_SCR_FIRST : cursor_reg + 3'h1;
		else if (down_key)
			cursor_reg <= (cursor_reg == `DSS_SCR_FIRST) ? `DSS_SCR_LAST : cursor_reg - 3'h1;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			nv_save_reg <= 1'b0;
		else
			nv_save_reg <= edit_reg & enter_key;
	end
	assign NV_SAVE_OUT = nv_save_reg;
	assign NV_MASK_OUT = eff_mask;

	// ========================================
	// screen selection
	function automatic logic [2:0] step_screen(input logic [2:0] cur, input logic [NUM_SCREENS-1:0] msk,
		input logic fwd);
		logic [2:0] res;
		logic [2:0] idx;
		logic found;
		res = cur;
		idx = cur;
		found = 1'b0;
		for (int k = 0; k < NUM_SCREENS; k++)
		begin
			if (fwd)
				idx = (idx == `DSS_SCR_LAST) ? `DSS_SCR_FIRST : idx + 3'h1;
			else
				idx = (idx == `DSS_SCR_FIRST) ? `DSS_SCR_LAST : idx - 3'h1;
			if (!found && msk[idx])
			begin
				res = idx;
				found = 1'b1;
			end
		end
		return res;
	endfunction

	logic dwell_done;
	logic dwell_clear;
	logic auto_step;
	assign auto_step = mode_reg & dwell_done & ~edit_reg;
	assign dwell_clear = ~mode_reg | auto_step;

	dss_sec_timer #(
		.WIDTH(DWELL_W)
	) u_dwell (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.clear_in(dwell_clear),
		.tick_in(sec_tick),
		.limit_in(dwell_reg),
		.reached_out(dwell_done)
	);

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			screen_reg <= `DSS_SCR_FIRST;
		else if (auto_step)
			screen_reg <= step_screen(screen_reg, eff_mask, 1'b1);
		else if (!mode_reg && !edit_reg && up_key)
			screen_reg <= step_screen(screen_reg, eff_mask, 1'b1);
		else if (!mode_reg && !edit_reg && down_key)
			screen_reg <= step_screen(screen_reg, eff_mask, 1'b0);
	end
	assign PROCESS_VIEW_OUT = screen_reg;
	assign EXTRA_DIGIT_OUT = prec_reg;

	// ========================================
	// screensaver
	logic idle_done;
	logic idle_clear;
	assign idle_clear = activity | (ss_state_reg == DSS_SS_ACTIVE);

	dss_sec_timer #(
		.WIDTH(SSTO_W)
	) u_idle (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.clear_in(idle_clear),
		.tick_in(sec_tick),
		.limit_in(ssto_reg),
		.reached_out(idle_done)
	);

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			ss_state_reg <= DSS_SS_IDLE;
			ss_lat_mode_reg <= DSS_SS_DISABLED;
			ss_lat_br_reg <= `DSS_RST_SSBR;
		end
		else
		begin
			unique case (ss_state_reg)
				DSS_SS_IDLE:
					if (!activity && idle_done && ssm_reg != DSS_SS_DISABLED)
					begin
						ss_state_reg <= DSS_SS_ACTIVE;
						ss_lat_mode_reg <= ssm_reg;
						ss_lat_br_reg <= ssbr_reg;
					end
				DSS_SS_ACTIVE:
					if (activity)
						ss_state_reg <= DSS_SS_IDLE;
			endcase
		end
	end

	// ========================================
	// panel drive
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			bright_reg <= `DSS_RST_OPBR;
			disp_on_reg <= 1'b1;
			scroll_reg <= 1'b0;
		end
		else if (ss_state_reg == DSS_SS_IDLE)
		begin
			bright_reg <= opbr_reg;
			disp_on_reg <= 1'b1;
			scroll_reg <= 1'b0;
		end
		else
		begin
			unique case (ss_lat_mode_reg)
				DSS_SS_LOW:
					bright_reg <= {1'b0, ss_lat_br_reg};
				DSS_SS_OFF:
					bright_reg <= 8'h00;
				default:
					bright_reg <= opbr_reg;
			endcase
			disp_on_reg <= (ss_lat_mode_reg != DSS_SS_OFF);
			scroll_reg <= (ss_lat_mode_reg == DSS_SS_SCROLL);
		end
	end
	assign BRIGHT_OUT = bright_reg;
	assign DISPLAY_ON_OUT = disp_on_reg;
	assign SCROLL_OUT = scroll_reg;
	assign SS_ACTIVE_OUT = (ss_state_reg == DSS_SS_ACTIVE);

	// ========================================
	// read data, captured in the setup cycle
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			prdata_reg <= 32'h00000000;
		else if (rd_en)
		begin
			prdata_reg <= 32'h00000000;
			unique case (PADDR_IN)
				`DSS_OFF_CTRL:
				begin
					prdata_reg[`DSS_CTRL_MODE] <= mode_reg;
					prdata_reg[`DSS_CTRL_PREC] <= prec_reg;
					prdata_reg[`DSS_CTRL_SSM_HI:`DSS_CTRL_SSM_LO] <= ssm_reg;
					prdata_reg[`DSS_CTRL_EDIT] <= edit_reg;
				end
				`DSS_OFF_DWELL:
					prdata_reg[DWELL_W-1:0] <= dwell_reg;
				`DSS_OFF_MASK:
					prdata_reg[NUM_SCREENS-1:0] <= eff_mask;
				`DSS_OFF_OPBR:
					prdata_reg[7:0] <= opbr_reg;
				`DSS_OFF_SSBR:
					prdata_reg[6:0] <= ssbr_reg;
				`DSS_OFF_SSTO:
					prdata_reg[SSTO_W-1:0] <= ssto_reg;
				`DSS_OFF_STAT:
					prdata_reg[7:0] <= {cursor_reg, ss_state_reg == DSS_SS_ACTIVE, 1'b0, screen_reg};
				default:
					prdata_reg <= 32'h00000000;
			endcase
		end
	end
endmodule

// *** test/dss_panel_model.sv ***
// pushbutton and seconds-tick model of the front panel
`timescale 1ns/1ps
`include "dss_cfg.svh"
module dss_panel_model (
	input wire logic clk_in,
	output logic [5:0] pins_out
);
	// ==========================================
	// pin pulses, long enough for the synchroniser
	initial pins_out = 6'h00;
	task press(input int k);
		pins_out[k] <= 1'b1;
		repeat (4) @(posedge clk_in);
		pins_out[k] <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask
	task tick(input int n);
		repeat (n) press(`DSS_KEY_TICK);
	endtask
endmodule

// *** test/dss_props.sv ***
// checker of the screen sequencer top-level outputs
`timescale 1ns/1ps
module dss_props_chk #(
	parameter int NUM_SCREENS = 6
)(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic NV_SAVE_OUT,
	input wire logic [NUM_SCREENS-1:0] NV_MASK_OUT,
	input wire logic [2:0] PROCESS_VIEW_OUT,
	input wire logic [7:0] BRIGHT_OUT,
	input wire logic DISPLAY_ON_OUT,
	input wire logic SCROLL_OUT,
	input wire logic SS_ACTIVE_OUT
);
	// ==========================================
	// sequences and properties
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	sequence s_wake; $fell(SS_ACTIVE_OUT); endsequence
	sequence s_lit; DISPLAY_ON_OUT && !SCROLL_OUT; endsequence
	property p_view; PROCESS_VIEW_OUT <= 3'h5; endproperty
	property p_first; NV_MASK_OUT[0]; endproperty
	property p_skip; $changed(PROCESS_VIEW_OUT) |-> NV_MASK_OUT[PROCESS_VIEW_OUT]; endproperty
	property p_save; NV_SAVE_OUT |=> !NV_SAVE_OUT; endproperty
	property p_scroll; SCROLL_OUT |-> DISPLAY_ON_OUT && (SS_ACTIVE_OUT || $past(SS_ACTIVE_OUT)); endproperty
	property p_off; !DISPLAY_ON_OUT |-> BRIGHT_OUT == 8'h00 && (SS_ACTIVE_OUT || $past(SS_ACTIVE_OUT)); endproperty
	property p_wake; s_wake |-> ##2 s_lit; endproperty
	property p_idle; !SS_ACTIVE_OUT [*3] |-> s_lit; endproperty
	a_view: assert property (p_view) else $error("view index out of range");
	a_first: assert property (p_first) else $error("first screen disabled");
	a_skip: assert property (p_skip) else $error("disabled screen shown");
	a_save: assert property (p_save) else $error("save pulse too long");
	a_scroll: assert property (p_scroll) else $error("scroll outside saver");
	a_off: assert property (p_off) else $error("panel off outside saver");
	a_wake: assert property (p_wake) else $error("panel not restored after wake");
	a_idle: assert property (p_idle) else $error("panel dimmed while idle");
endmodule
bind dss_top dss_props_chk #(.NUM_SCREENS(NUM_SCREENS)) u_props (.*);

// *** test/tb_top.sv ***
// testbench of the screen sequencer
`timescale 1ns/1ps
`include "dss_cfg.svh"
module tb_top;
	logic clk, rst, psel, pen, pwr, nv_load, e, nv_mode;
	logic [11:0] nv_dwell;
	logic [7:0] paddr;
	logic [31:0] pwdata, rdat, rv;
	logic rdy, serr, save, don, scr, extra, ssa;
	logic [5:0] pins, mask_o, nv_mask;
	logic [2:0] view;
	logic [7:0] bright, nv_opbr;
	int err_count, n_compared, cyc, saves;
	logic [31:0] rst_tab [6] = '{32'h08, 32'h00A, 32'h3F, 32'h7F, 32'h20, 32'h384};
	logic [2:0] up_tab [4] = '{3'h1, 3'h3, 3'h5, 3'h0};
	logic [2:0] dyn_tab [4] = '{3'h5, 3'h0, 3'h0, 3'h1};
	logic [1:0] ss_md [3] = '{2'h1, 2'h3, 2'h2};
	logic [7:0] ss_br [3] = '{8'h10, 8'h00, 8'h40};
	logic ss_on [3] = '{1'b1, 1'b0, 1'b1};
	logic ss_sc [3] = '{1'b0, 1'b0, 1'b1};
	dss_panel_model u_panel (.clk_in(clk), .pins_out(pins));
	dss_top u_dut (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(rdat), .PREADY_OUT(rdy), .PSLVERR_OUT(serr),
		.KEY_UP_IN(pins[`DSS_KEY_UP]), .DOWN_KEY_IN(pins[`DSS_KEY_DOWN]), .KEY_RIGHT_IN(pins[`DSS_KEY_RIGHT]),
		.ENTER_KEY_IN(pins[`DSS_KEY_ENTER]), .KEY_ESC_IN(pins[`DSS_KEY_ESC]), .SEC_TICK_IN(pins[`DSS_KEY_TICK]),
		.NV_LOAD_IN(nv_load), .NV_MODE_IN(nv_mode), .NV_DWELL_IN(nv_dwell), .NV_MASK_IN(nv_mask),
		.NV_OPBR_IN(nv_opbr), .NV_SAVE_OUT(save), .NV_MASK_OUT(mask_o), .PROCESS_VIEW_OUT(view),
		.BRIGHT_OUT(bright), .DISPLAY_ON_OUT(don), .SCROLL_OUT(scr), .EXTRA_DIGIT_OUT(extra),
		.SS_ACTIVE_OUT(ssa));
	// ==========================================
	// clock, timeout and helpers
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (save === 1'b1) saves++;
		if (cyc == 20000)
		begin
			err_count++;
			stop_test();
		end
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		rv = rdat;
		e = serr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task rdchk(input string n, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(n, rv, x);
	endtask
	task stop_test;
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		{rst, psel, pen, pwr, nv_load} = 5'h10;
		paddr = 8'h00;
		pwdata = 32'h0;
		{nv_mode, nv_dwell, nv_mask, nv_opbr} = 27'h0000000;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 6; i++) rdchk("reset reg", 8'(4 * i), rst_tab[i]);
		chk("view", view, 0);
		chk("bright", bright, 8'h7F);
		chk("extra rst", extra, 0);
		rdchk("unmapped", 8'h1C, 0);
		chk("slverr", e, 1);
		apb(1'b1, `DSS_OFF_MASK, 32'h3E);
		rdchk("mask", `DSS_OFF_MASK, 32'h3F);
		apb(1'b1, `DSS_OFF_MASK, 32'h2B);
		for (int i = 0; i < 4; i++)
		begin
			u_panel.press(`DSS_KEY_UP);
			chk("up view", view, up_tab[i]);
		end
		u_panel.press(`DSS_KEY_DOWN);
		chk("down view", view, 5);
		apb(1'b1, `DSS_OFF_DWELL, 32'h2);
		apb(1'b1, `DSS_OFF_CTRL, 32'h0B);
		chk("extra", extra, 1);
		for (int i = 0; i < 4; i++)
		begin
			u_panel.tick(1);
			chk("dyn view", view, dyn_tab[i]);
		end
		apb(1'b1, `DSS_OFF_DWELL, 32'h0);
		rdchk("dwell lo", `DSS_OFF_DWELL, 32'h1);
		apb(1'b1, `DSS_OFF_DWELL, 32'hE11);
		rdchk("dwell hi", `DSS_OFF_DWELL, 32'hE10);
		apb(1'b1, `DSS_OFF_OPBR, 32'h40);
		apb(1'b1, `DSS_OFF_SSBR, 32'h7F);
		rdchk("ssbr", `DSS_OFF_SSBR, 32'h7E);
		apb(1'b1, `DSS_OFF_SSBR, 32'h10);
		apb(1'b1, `DSS_OFF_SSTO, 32'h3);
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, `DSS_OFF_CTRL, {ss_md[i], 2'b00});
			u_panel.press(`DSS_KEY_ESC);
			chk("woken", ssa, 0);
			chk("woken bright", bright, 8'h40);
			u_panel.tick(2);
			chk("early saver", ssa, 0);
			u_panel.tick(1);
			chk("saver", ssa, 1);
			chk("saver bright", bright, ss_br[i]);
			chk("saver on", don, ss_on[i]);
			chk("saver scroll", scr, ss_sc[i]);
			apb(1'b1, `DSS_OFF_CTRL, 32'h0);
			chk("kept bright", bright, ss_br[i]);
		end
		u_panel.press(`DSS_KEY_ESC);
		u_panel.tick(5);
		chk("disabled saver", ssa, 0);
		apb(1'b1, `DSS_OFF_CTRL, 32'h10);
		u_panel.press(`DSS_KEY_UP);
		u_panel.press(`DSS_KEY_RIGHT);
		rdchk("edit mask", `DSS_OFF_MASK, 32'h29);
		chk("edit view", view, 1);
		rdchk("stat", `DSS_OFF_STAT, 32'h21);
		u_panel.press(`DSS_KEY_ENTER);
		chk("saves", saves, 1);
		chk("saved mask", mask_o, 6'h29);
		nv_mode <= 1'b1;
		nv_dwell <= 12'h005;
		nv_mask <= 6'h0F;
		nv_opbr <= 8'h55;
		nv_load <= 1'b1;
		@(posedge clk);
		nv_load <= 1'b0;
		@(posedge clk);
		rdchk("nv mask", `DSS_OFF_MASK, 32'h0F);
		rdchk("nv opbr", `DSS_OFF_OPBR, 32'h55);
		rdchk("nv dwell", `DSS_OFF_DWELL, 32'h5);
		rdchk("nv mode", `DSS_OFF_CTRL, 32'h11);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("rst view", view, 0);
		rdchk("rst mask", `DSS_OFF_MASK, 32'h3F);
		stop_test();
	end
endmodule
